// [hdl/piwc_pkg.sv]
/*
  piwc_pkg: constants and types for the priority interrupt and wake controller.
  Assumes one 100 MHz clock; every other rate comes from enable pulses.
*/
package piwc_pkg;
  // vector count and layout
  localparam int NUM_VEC = 10;
  localparam int NUM_SRC = 22;
  localparam logic [19:0] VEC_BASE = 20'h00003;
  localparam logic [19:0] VEC_STEP = 20'h00008;
  // instruction cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int INSTR_CYCLE_NS = 300;
  localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // noise filter time constants, in instruction cycles
  localparam int FILT_SHORT_CYC = 1;
  localparam int FILT_MID_CYC = 32;
  localparam int FILT_LONG_CYC = 128;
  // service levels, ordered by numeric value
  typedef enum logic [1:0] {
    PIWC_LVL_NONE = 2'h0,
    PIWC_LVL_LOW = 2'h1,
    PIWC_LVL_HIGH = 2'h2,
    PIWC_LVL_TOP = 2'h3
  } piwc_lvl_t;
  // sense modes for external inputs
  typedef enum logic [2:0] {
    PIWC_SENSE_RISE = 3'h0,
    PIWC_SENSE_FALL = 3'h1,
    PIWC_SENSE_BOTH = 3'h2,
    PIWC_SENSE_HIGH = 3'h3,
    PIWC_SENSE_LOW = 3'h4
  } piwc_sense_t;
  // filter selection
  typedef enum logic [1:0] {
    PIWC_FILT_1 = 2'h0,
    PIWC_FILT_32 = 2'h1,
    PIWC_FILT_128 = 2'h2
  } piwc_filt_t;
  // standby modes
  typedef enum logic [1:0] {
    PIWC_MODE_RUN = 2'h0,
    PIWC_MODE_HALT = 2'h1,
    PIWC_MODE_HOLD = 2'h2,
    PIWC_MODE_XHOLD = 2'h3
  } piwc_mode_t;
endpackage : piwc_pkg

// [hdl/piwc_sense_if.sv]
/*
  piwc_sense_if: carries one external pin, its sense mode and its event.
  Assumes the sense module and the main controller share ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface piwc_sense_if;
  import piwc_pkg::*;
  logic pin;
  piwc_sense_t mode;
  logic event_hit;
  logic level_now;
  modport ctrl (output pin, output mode, input event_hit, input level_now);
  modport sense (input pin, input mode, output event_hit, output level_now);
endinterface : piwc_sense_if
`default_nettype wire

// [hdl/piwc_sense.sv]
/*
  piwc_sense: optional noise filter and edge or level detection for one pin.
  Assumes the pin is synchronous to ref_clk and tick is one pulse per
  instruction cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module piwc_sense
  import piwc_pkg::*;
#(
  parameter bit HAS_FILTER = 1'b0
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // instruction cycle tick and filter choice
  input wire logic tick,
  input wire piwc_filt_t filt_sel,
  // pin side
  piwc_sense_if.sense sif
);
  logic clean_q;
  logic prev_q;
  logic [7:0] cnt_q;
  logic [7:0] limit;

  // filter length in instruction cycles
  always_comb
  begin
    case (filt_sel)
      PIWC_FILT_32: limit = 8'(FILT_MID_CYC);
      PIWC_FILT_128: limit = 8'(FILT_LONG_CYC);
      default: limit = 8'(FILT_SHORT_CYC);
    endcase
  end

  // R07 noise rejection filter
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      clean_q <= sif.pin; // start at the pin level, no false edge
      cnt_q <= 8'h00;
    end
    else if (!HAS_FILTER)
      clean_q <= sif.pin;
    else if (sif.pin == clean_q)
      cnt_q <= 8'h00;
    else if (tick)
    begin
      if (cnt_q + 8'h01 >= limit)
      begin
        clean_q <= sif.pin;
        cnt_q <= 8'h00;
      end
      else
        cnt_q <= cnt_q + 8'h01;
    end
  end

  // previous value for edge detection
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      prev_q <= sif.pin;
    else
      prev_q <= clean_q;
  end

  // R05 R06 sense decode
  always_comb
  begin
    case (sif.mode)
      PIWC_SENSE_RISE: sif.event_hit = clean_q & ~prev_q;
      PIWC_SENSE_FALL: sif.event_hit = ~clean_q & prev_q;
      PIWC_SENSE_BOTH: sif.event_hit = clean_q ^ prev_q;
      PIWC_SENSE_HIGH: sif.event_hit = clean_q;
      PIWC_SENSE_LOW: sif.event_hit = ~clean_q;
      default: sif.event_hit = 1'b0;
    endcase
  end
  assign sif.level_now = (sif.mode == PIWC_SENSE_LOW) ? ~clean_q : clean_q;

  // filter cover
  filt_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
    HAS_FILTER && $changed(clean_q));
endmodule : piwc_sense
`default_nettype wire

// [hdl/piwc_top.sv]
/*
  piwc_top: three-level priority interrupt controller with wake logic.
  Assumes the core takes a vector on irq_req with irq_ack and signals the
  end of a handler with irq_ret; all inputs are synchronous to ref_clk.
*/
// Behaviour
// R01: three nested levels; block equal or lower
// R02: grant highest level, then smallest vector
// R03: twenty-two sources merged onto ten vectors
// R04: vectors 03H..4BH step eight; level choices
// R05: ext zero, one: edges or levels
// R06: ext two, three, five: edges only
// R07: ext three filtered, 1/32/128 cycles
// R08: halt ends on reset or interrupt
// R09: deep hold stops core, peripherals, oscillators
// R10: deep hold woken by pins, port zero
// R11: crystal hold keeps crystal and base timer
// R12: crystal hold also woken by base timer
// R13: accept raises level; return restores it
// R14: blocked request stays pending until granted
`timescale 1ns/10ps
`default_nettype none
module piwc_top
  import piwc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // external interrupt pins
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic ext_irq_two,
  input wire logic ext_irq_three,
  input wire logic ext_irq_four,
  input wire logic ext_irq_five,
  // sense and filter configuration
  input wire piwc_sense_t sense_zero,
  input wire piwc_sense_t sense_one,
  input wire piwc_sense_t sense_two,
  input wire piwc_sense_t sense_three,
  input wire piwc_sense_t sense_four,
  input wire piwc_sense_t sense_five,
  input wire piwc_filt_t filt_sel,
  // peripheral event pulses
  input wire logic timer_zero_low_event,
  input wire logic timer_zero_high_event,
  input wire logic base_timer_event,
  input wire logic timer_one_low_event,
  input wire logic timer_one_high_event,
  input wire logic sync_serial_zero,
  input wire logic sync_serial_one,
  input wire logic async_serial_rx,
  input wire logic async_serial_tx,
  input wire logic adc_done_event,
  input wire logic timer_six_event,
  input wire logic timer_seven_event,
  input wire logic port_zero_event,
  input wire logic timer_four_event,
  input wire logic timer_five_event,
  input wire logic pulse_out_zero,
  input wire logic pulse_out_one,
  // per-vector enable and level choice (1 = top/high, 0 = low)
  input wire logic [9:0] vec_enable,
  input wire logic [9:0] vec_level_hi,
  // source flag clears, one per source
  input wire logic [21:0] src_clear,
  // core handshake
  input wire logic irq_ack,
  input wire logic irq_ret,
  // standby control
  input wire piwc_mode_t mode_enter,
  input wire logic mode_enter_stb,
  input wire logic reset_pin_n,
  // outputs
  output logic [21:0] src_flag_q,
  output logic irq_req_q,
  output logic [19:0] irq_vec_q,
  output piwc_lvl_t svc_lvl_q,
  output piwc_mode_t mode_q,
  output logic core_run_q,
  output logic periph_run_q,
  output logic ceramic_oscillator_run_q,
  output logic internal_rc_oscillator_run_q,
  output logic crystal_run_q,
  output logic base_timer_run_q
);
  logic [$clog2(INSTR_CYCLE_CLKS)-1:0] div_q;
  logic tick;
  logic [21:0] src_hit;
  logic [9:0] vec_pend;
  logic [3:0] win_idx;
  piwc_lvl_t win_lvl;
  logic win_any;
  logic [9:0] beat_win;
  logic [3:0] idx_q;
  piwc_lvl_t stk_q [0:2];
  logic [1:0] depth_q;
  logic wake_pins;
  logic crystal_entry_q;
  piwc_sense_if s_if [0:5] ();
  logic [5:0] pins;
  piwc_sense_t modes [0:5];
  logic [5:0] ext_hit;
  logic [5:0] ext_lvl;

  // level assigned to a vector by its configuration
  function automatic piwc_lvl_t vec_lvl(input int v, input logic hi);
    if (!hi)
      return PIWC_LVL_LOW;
    return (v < 2) ? PIWC_LVL_TOP : PIWC_LVL_HIGH;
  endfunction : vec_lvl

  // instruction cycle tick divider
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      div_q <= '0;
    else
      div_q <= (div_q == INSTR_CYCLE_CLKS - 1) ? '0 : div_q + 1'b1;
  end
  assign tick = (div_q == '0);

  // sense channels for the six pins
  assign pins = {ext_irq_five, ext_irq_four, ext_irq_three, ext_irq_two,
                 ext_irq_one, ext_irq_zero};
  assign modes[0] = sense_zero;
  assign modes[1] = sense_one;
  // R06 fold level codes back to edges
  assign modes[2] = (sense_two > PIWC_SENSE_BOTH) ? PIWC_SENSE_RISE : sense_two;
  assign modes[3] = (sense_three > PIWC_SENSE_BOTH) ? PIWC_SENSE_RISE : sense_three;
  assign modes[4] = sense_four;
  assign modes[5] = (sense_five > PIWC_SENSE_BOTH) ? PIWC_SENSE_RISE : sense_five;
  for (genvar g = 0; g < 6; g++)
  begin : g_sense
    assign s_if[g].pin = pins[g];
    // R05 both edges not offered on zero and one
    assign s_if[g].mode = (g < 2 && modes[g] == PIWC_SENSE_BOTH) ? PIWC_SENSE_RISE : modes[g];
    assign ext_hit[g] = s_if[g].event_hit;
    assign ext_lvl[g] = s_if[g].level_now;
    // R07 filter only on ext three
    piwc_sense #(.HAS_FILTER(g == 3)) u_sense (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .filt_sel(filt_sel),
      .sif(s_if[g])
    );
  end

  // R03 source order grouped by vector
  assign src_hit = {pulse_out_one | pulse_out_zero, timer_five_event, timer_four_event,
                    port_zero_event, timer_seven_event, timer_six_event, adc_done_event,
                    async_serial_tx, sync_serial_one, async_serial_rx, sync_serial_zero,
                    timer_one_high_event, timer_one_low_event, timer_zero_high_event,
                    base_timer_event, ext_hit[5], ext_hit[3], ext_hit[4],
                    timer_zero_low_event, ext_hit[2], ext_hit[1], ext_hit[0]};

  // R14 sticky flags, set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      src_flag_q <= 22'h000000;
    else
      src_flag_q <= (src_flag_q & ~src_clear) | src_hit;
  end

  // R03 merge flags onto vectors
  assign vec_pend = vec_enable & {|src_flag_q[21:18], |src_flag_q[17:15],
                    |src_flag_q[14:13], |src_flag_q[12:11], |src_flag_q[10:9],
                    src_flag_q[8], |src_flag_q[7:5], |src_flag_q[4:2],
                    src_flag_q[1], src_flag_q[0]};

  // R02 arbitration: highest level, then smallest vector
  always_comb
  begin
    win_any = 1'b0;
    win_idx = 4'h0;
    win_lvl = PIWC_LVL_NONE;
    beat_win = 10'h000;
    for (int v = NUM_VEC - 1; v >= 0; v--)
    begin
      if (vec_pend[v] && vec_lvl(v, vec_level_hi[v]) >= win_lvl)
      begin
        win_any = 1'b1;
        win_idx = 4'(v);
        win_lvl = vec_lvl(v, vec_level_hi[v]);
      end
    end
    // pending vectors that ought to have beaten the winner, for the check
    for (int v = 0; v < NUM_VEC; v++)
      beat_win[v] = vec_pend[v] && (vec_lvl(v, vec_level_hi[v]) > win_lvl ||
                    vec_lvl(v, vec_level_hi[v]) == win_lvl && 4'(v) < win_idx);
  end

  // R01 offer only above current level; R04 vector address
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irq_req_q <= 1'b0;
      irq_vec_q <= 20'h00000;
      idx_q <= 4'h0;
    end
    else if (irq_req_q && irq_ack)
      irq_req_q <= 1'b0;
    else if (core_run_q || !irq_req_q)
    begin
      irq_req_q <= win_any && win_lvl > svc_lvl_q;
      irq_vec_q <= VEC_BASE + VEC_STEP * 20'(win_idx);
      idx_q <= win_idx;
    end
  end

  // R13 level stack: push on accept, pop on return
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      svc_lvl_q <= PIWC_LVL_NONE;
      depth_q <= 2'h0;
      for (int i = 0; i < 3; i++)
        stk_q[i] <= PIWC_LVL_NONE;
    end
    else if (irq_req_q && irq_ack)
    begin
      stk_q[depth_q] <= svc_lvl_q;
      depth_q <= depth_q + 2'h1;
      svc_lvl_q <= vec_lvl(int'(idx_q), vec_level_hi[idx_q]);
    end
    else if (irq_ret && depth_q != 2'h0)
    begin
      svc_lvl_q <= stk_q[depth_q - 2'h1];
      depth_q <= depth_q - 2'h1;
    end
  end

  // R10 R12 wake pins (ext zero, one, two, four, five)
  assign wake_pins = |(ext_hit & 6'h37) | ext_lvl[0] & (sense_zero >= PIWC_SENSE_HIGH)
                   | ext_lvl[1] & (sense_one >= PIWC_SENSE_HIGH);

  // standby mode sequencing
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !reset_pin_n)
      mode_q <= PIWC_MODE_RUN;
    else
    begin
      case (mode_q)
        PIWC_MODE_RUN:
          if (mode_enter_stb)
            mode_q <= mode_enter;
        // R08 halt ends on any interrupt
        PIWC_MODE_HALT:
          if (|src_hit)
            mode_q <= PIWC_MODE_RUN;
        // R10 deep hold wake paths
        PIWC_MODE_HOLD:
          if (wake_pins || port_zero_event)
            mode_q <= PIWC_MODE_RUN;
        // R12 crystal hold adds base timer
        PIWC_MODE_XHOLD:
          if (wake_pins || port_zero_event || base_timer_event)
            mode_q <= PIWC_MODE_RUN;
        default:
          mode_q <= PIWC_MODE_RUN;
      endcase
    end
  end

  // R09 R11 run controls registered from the current mode
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      core_run_q <= 1'b1;
      periph_run_q <= 1'b1;
      ceramic_oscillator_run_q <= 1'b1;
      internal_rc_oscillator_run_q <= 1'b1;
      crystal_run_q <= 1'b1;
      base_timer_run_q <= 1'b1;
      crystal_entry_q <= 1'b1;
    end
    else
    begin
      core_run_q <= (mode_q == PIWC_MODE_RUN);
      periph_run_q <= (mode_q == PIWC_MODE_RUN) || (mode_q == PIWC_MODE_HALT);
      ceramic_oscillator_run_q <= (mode_q == PIWC_MODE_RUN) || (mode_q == PIWC_MODE_HALT);
      internal_rc_oscillator_run_q <= (mode_q == PIWC_MODE_RUN) || (mode_q == PIWC_MODE_HALT);
      base_timer_run_q <= (mode_q != PIWC_MODE_HOLD);
      if (mode_q != PIWC_MODE_XHOLD)
        crystal_entry_q <= (mode_q != PIWC_MODE_HOLD);
      // R11 crystal keeps state held on entry
      crystal_run_q <= (mode_q == PIWC_MODE_XHOLD) ? crystal_entry_q
                     : (mode_q != PIWC_MODE_HOLD);
    end
  end

  // checks
  no_equal_offer_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R01
    $rose(irq_req_q) |-> win_lvl > svc_lvl_q || $past(win_lvl) > $past(svc_lvl_q))
    else $error("request offered at or below service level");
  vec_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R04
    irq_req_q |-> irq_vec_q >= 20'h00003 && irq_vec_q <= 20'h0004B && irq_vec_q[2:0] == 3'h3)
    else $error("vector out of range");
  prio_pick_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R02
    win_any |-> vec_pend[win_idx] && beat_win == 10'h000)
    else $error("winner not pending");
  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R14
    src_flag_q[9] && !src_clear[9] |=> src_flag_q[9])
    else $error("pending flag lost");
  flag_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R03
    src_hit[12] |=> src_flag_q[12] && vec_pend[6] == vec_enable[6])
    else $error("source did not raise its vector");
  level_raise_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    irq_req_q && irq_ack |=> svc_lvl_q > $past(svc_lvl_q))
    else $error("service level not raised");
  level_pop_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    irq_ret && !(irq_req_q && irq_ack) && depth_q == 2'h1 |=> svc_lvl_q == PIWC_LVL_NONE)
    else $error("level not restored");
  hold_osc_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R09
    mode_q == PIWC_MODE_HOLD |=> !ceramic_oscillator_run_q && !crystal_run_q && !core_run_q)
    else $error("oscillators run in deep hold");
  xhold_wake_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R12
    mode_q == PIWC_MODE_XHOLD && base_timer_event && reset_pin_n |=> mode_q == PIWC_MODE_RUN)
    else $error("base timer failed to wake");
  halt_wake_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R08
    mode_q == PIWC_MODE_HALT && |src_hit |=> mode_q == PIWC_MODE_RUN ##1 core_run_q)
    else $error("halt not ended by interrupt");
  nest_c: cover property (@(posedge ref_clk) depth_q == 2'h2);
  hold_wake_c: cover property (@(posedge ref_clk) mode_q == PIWC_MODE_HOLD ##1 mode_q == PIWC_MODE_RUN);
  blocked_c: cover property (@(posedge ref_clk) win_any && win_lvl <= svc_lvl_q ##[1:50] irq_req_q);
endmodule : piwc_top
`default_nettype wire

// [dv/piwc_core_model.sv]
/*
  piwc_core_model: processor core that takes vectors, clears the vector's
  source flags and returns from each handler after hold_cyc cycles.
  Assumes the controller outputs are registered on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module piwc_core_model
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // controller side
  input wire logic irq_req_q,
  input wire logic [19:0] irq_vec_q,
  output logic irq_ack,
  output logic irq_ret,
  output logic [21:0] src_clear,
  // pacing from the bench
  input wire logic [3:0] ack_dly,
  input wire logic [7:0] hold_cyc,
  output logic [19:0] taken_vec
);
  int wait_n, run_n, depth, idx;
  int lo[10] = '{0, 1, 2, 5, 8, 9, 11, 13, 15, 18};
  int hi[10] = '{0, 1, 4, 7, 8, 10, 12, 14, 17, 21};
  initial
  begin
    irq_ack = 1'b0;
    irq_ret = 1'b0;
    src_clear = '0;
    taken_vec = '0;
    depth = 0;
    wait_n = 0;
    run_n = 0;
  end
  // drive just after each edge; hold ack until the edge that takes it
  always @(posedge ref_clk)
  begin
    #1;
    irq_ret = 1'b0;
    if (sys_rst)
    begin
      irq_ack = 1'b0;
      src_clear = '0;
      depth = 0;
      wait_n = 0;
    end
    else if (irq_ack)
    begin
      irq_ack = 1'b0;
      src_clear = '0;
      depth++;
      run_n = hold_cyc;
    end
    else if (irq_req_q && wait_n >= ack_dly)
    begin
      irq_ack = 1'b1;
      taken_vec = irq_vec_q;
      idx = (irq_vec_q - 3) / 8;
      for (int b = lo[idx]; b <= hi[idx]; b++) src_clear[b] = 1'b1;
      wait_n = 0;
    end
    else if (irq_req_q)
      wait_n++;
    // handler return, innermost first
    if (!sys_rst && depth > 0 && !irq_ack)
    begin
      if (run_n > 0) run_n--;
      else
      begin
        irq_ret = 1'b1;
        depth--;
        run_n = hold_cyc;
      end
    end
  end
endmodule : piwc_core_model
`default_nettype wire

// [dv/piwc_top_tb.sv]
/*
  piwc_top_tb: self-checking bench for piwc_top with a core model.
  Assumes the pin and event inputs are synchronous to ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module piwc_top_tb;
  import piwc_pkg::*;
  logic ref_clk, sys_rst, mode_enter_stb, reset_pin_n, irq_ack, irq_ret, irq_req_q;
  logic [5:0] pin_v, run_v;
  logic [21:0] src_drv, src_clear, src_flag_q, exp_e;
  logic [19:0] irq_vec_q, taken_vec;
  logic [9:0] vec_enable, vec_level_hi;
  logic [3:0] ack_dly;
  logic [7:0] hold_cyc;
  piwc_sense_t sns[6];
  piwc_filt_t filt_sel;
  piwc_mode_t mode_enter, mode_q;
  piwc_lvl_t svc_lvl_q;
  logic [21:0] exp_q[$];
  int seed, miscompares, total_checks, cyc;
  int lo[10] = '{0, 1, 2, 5, 8, 9, 11, 13, 15, 18};
  int hi[10] = '{0, 1, 4, 7, 8, 10, 12, 14, 17, 21};
  piwc_mode_t sb_mode[5] = '{PIWC_MODE_HALT, PIWC_MODE_HOLD, PIWC_MODE_XHOLD, PIWC_MODE_HOLD,
    PIWC_MODE_HOLD};
  logic [5:0] sb_run[5] = '{6'h1F, 6'h00, 6'h03, 6'h00, 6'h00};
  int sb_wake[5] = '{8, 18, 7, -1, 6};

  // clock and timeout
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  piwc_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .ext_irq_zero(pin_v[0]), .ext_irq_one(pin_v[1]), .ext_irq_two(pin_v[2]),
    .ext_irq_three(pin_v[3]), .ext_irq_four(pin_v[4]), .ext_irq_five(pin_v[5]),
    .sense_zero(sns[0]), .sense_one(sns[1]), .sense_two(sns[2]), .sense_three(sns[3]),
    .sense_four(sns[4]), .sense_five(sns[5]), .filt_sel(filt_sel),
    .timer_zero_low_event(src_drv[3]), .timer_zero_high_event(src_drv[8]),
    .base_timer_event(src_drv[7]), .timer_one_low_event(src_drv[9]),
    .timer_one_high_event(src_drv[10]), .sync_serial_zero(src_drv[11]),
    .sync_serial_one(src_drv[13]), .async_serial_rx(src_drv[12]),
    .async_serial_tx(src_drv[14]), .adc_done_event(src_drv[15]),
    .timer_six_event(src_drv[16]), .timer_seven_event(src_drv[17]),
    .port_zero_event(src_drv[18]), .timer_four_event(src_drv[19]),
    .timer_five_event(src_drv[20]), .pulse_out_zero(src_drv[21]),
    .pulse_out_one(src_drv[21]), .vec_enable(vec_enable), .vec_level_hi(vec_level_hi),
    .src_clear(src_clear), .irq_ack(irq_ack), .irq_ret(irq_ret), .mode_enter(mode_enter),
    .mode_enter_stb(mode_enter_stb), .reset_pin_n(reset_pin_n), .src_flag_q(src_flag_q),
    .irq_req_q(irq_req_q), .irq_vec_q(irq_vec_q), .svc_lvl_q(svc_lvl_q), .mode_q(mode_q),
    .core_run_q(run_v[5]), .periph_run_q(run_v[4]), .ceramic_oscillator_run_q(run_v[3]),
    .internal_rc_oscillator_run_q(run_v[2]), .crystal_run_q(run_v[1]),
    .base_timer_run_q(run_v[0]));

  piwc_core_model core (.ref_clk(ref_clk), .sys_rst(sys_rst), .irq_req_q(irq_req_q),
    .irq_vec_q(irq_vec_q), .irq_ack(irq_ack), .irq_ret(irq_ret), .src_clear(src_clear),
    .ack_dly(ack_dly), .hold_cyc(hold_cyc), .taken_vec(taken_vec));

  task automatic check(input string name, input logic [21:0] seen, input logic [21:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // expected level and address of the vector that source b raises
  function automatic logic [21:0] exp_of(input int b);
    int v;
    logic [1:0] l;
    v = 0;
    for (int i = 0; i < 10; i++) if (b >= lo[i] && b <= hi[i]) v = i;
    l = !vec_level_hi[v] ? PIWC_LVL_LOW : (v < 2) ? PIWC_LVL_TOP : PIWC_LVL_HIGH;
    return {l, VEC_BASE + VEC_STEP * 20'(v)};
  endfunction : exp_of

  // raise source b through its pin or its event pulse, noting the result
  task automatic fire(input int b);
    int p;
    p = (b < 3) ? b : (b == 4) ? 4 : (b == 5) ? 3 : (b == 6) ? 5 : -1;
    exp_q.push_back(exp_of(b));
    if (p >= 0)
    begin
      pin_v[p] = ~pin_v[p];
      repeat (80) @(posedge ref_clk);
      #1 pin_v[p] = ~pin_v[p];
    end
    else
    begin
      src_drv[b] = 1'b1;
      @(posedge ref_clk);
      #1 src_drv[b] = 1'b0;
    end
  endtask : fire

  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || core.depth != 0) && n < 3000)
    begin
      @(posedge ref_clk);
      n++;
    end
    #1 if (n == 3000) check("drain", 22'h1, 22'h0);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : drain

  // scoreboard: each taken vector against the oldest note
  always @(posedge ref_clk)
  begin
    if (irq_ack === 1'b1)
    begin
      #2;
      if (exp_q.size() == 0) exp_e = '1;
      else exp_e = exp_q.pop_front();
      check("vector", {2'h0, taken_vec}, {2'h0, exp_e[19:0]});
      check("level", {20'h0, svc_lvl_q}, {20'h0, exp_e[21:20]});
    end
  end

  initial
  begin
    seed = 50670;
    {miscompares, total_checks, cyc} = '0;
    sys_rst = 1'b1;
    pin_v = 6'h02;
    sns = '{PIWC_SENSE_RISE, PIWC_SENSE_FALL, PIWC_SENSE_RISE, PIWC_SENSE_RISE,
      PIWC_SENSE_RISE, PIWC_SENSE_RISE};
    filt_sel = PIWC_FILT_1;
    {src_drv, mode_enter_stb} = '0;
    mode_enter = PIWC_MODE_RUN;
    reset_pin_n = 1'b1;
    vec_enable = 10'h3FF;
    vec_level_hi = 10'h000;
    ack_dly = 4'h0;
    hold_cyc = 8'h28;
    repeat (20) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    // every vector through a random source of it, random level and pace
    for (int v = 0; v < 10; v++)
    begin
      vec_level_hi = 10'($random(seed));
      ack_dly = 4'($random(seed));
      fire(lo[v] + $unsigned($random(seed)) % (hi[v] - lo[v] + 1));
      drain();
    end
    // same cycle: low pair by address, then high beats low
    vec_level_hi = 10'h000;
    for (int k = 0; k < 2; k++)
    begin
      exp_q.push_back(exp_of(k ? 11 : 9));
      exp_q.push_back(exp_of(k ? 9 : 11));
      src_drv = 22'h000A00;
      @(posedge ref_clk);
      #1 src_drv = '0;
      drain();
      vec_level_hi = 10'h040;
    end
    // equal level blocked and kept pending, high one nests
    vec_level_hi = 10'h010;
    ack_dly = 4'h0;
    fire(9);
    repeat (6) @(posedge ref_clk);
    #1 fire(13);
    repeat (5) @(posedge ref_clk);
    #1 check("blocked req", {21'h0, irq_req_q}, 22'h0);
    check("pending flag", {21'h0, src_flag_q[13]}, 22'h1);
    exp_q.push_front(exp_of(8));
    fire(8);
    void'(exp_q.pop_back());
    drain();
    // standby modes, run outputs and wake paths
    vec_level_hi = 10'h000;
    for (int m = 0; m < 5; m++)
    begin
      mode_enter = sb_mode[m];
      mode_enter_stb = 1'b1;
      @(posedge ref_clk);
      #1 mode_enter_stb = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 check("mode", {20'h0, mode_q}, {20'h0, sb_mode[m]});
      check("run", {16'h0, run_v}, {16'h0, sb_run[m]});
      if (sb_wake[m] >= 0) fire(sb_wake[m]);
      else
      begin
        reset_pin_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 reset_pin_n = 1'b1;
      end
      repeat (10) @(posedge ref_clk);
      #1 check("woken", {20'h0, mode_q}, {20'h0, PIWC_MODE_RUN});
      check("run up", {16'h0, run_v}, 22'h3F);
      drain();
    end
    // noise filter: short glitch dropped, long level passes
    filt_sel = PIWC_FILT_32;
    pin_v[3] = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1 pin_v[3] = 1'b0;
    repeat (200) @(posedge ref_clk);
    #1 check("glitch", {21'h0, src_flag_q[5]}, 22'h0);
    exp_q.push_back(exp_of(5));
    pin_v[3] = 1'b1;
    repeat (2500) @(posedge ref_clk);
    #1 pin_v[3] = 1'b0;
    drain();
    report_and_stop();
  end
endmodule : piwc_top_tb
`default_nettype wire
